// *** common/timer2_pkg.sv ***
package timer2_pkg;

  // ----------------------------------------------------------------
  // Special-function register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL     = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW   = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hCD;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int BIT_HIGH_FLAG  = 7;
  localparam int BIT_LOW_FLAG   = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_CAPTURE_EN = 4;
  localparam int BIT_SPLIT      = 3;
  localparam int BIT_RUN        = 2;
  localparam int BIT_XCLK_HI    = 1;
  localparam int BIT_XCLK_LO    = 0;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX   = 8'hFF;

  // ----------------------------------------------------------------
  // Clock source selection codes
  // ----------------------------------------------------------------
  localparam logic [1:0] XCLK_DIV12_A = 2'h0;
  localparam logic [1:0] XCLK_CMP0    = 2'h1;
  localparam logic [1:0] XCLK_DIV12_B = 2'h2;
  localparam logic [1:0] XCLK_RTC8    = 2'h3;

  // ----------------------------------------------------------------
  // Prescaler counts and synchroniser width
  // ----------------------------------------------------------------
  localparam logic [3:0] CORE_DIV_LAST = 4'hB;
  localparam logic [2:0] RTC_DIV_LAST  = 3'h7;
  localparam int         SYNC_STAGES   = 2;

endpackage

// *** logic/sync_level.sv ***
`timescale 1ns/1ps
module sync_level #(
  parameter int WIDTH = 2
) (
  input  wire logic             MCLK_I,
  input  wire logic             RST_I,
  input  wire logic             CE_I,
  input  wire logic [WIDTH-1:0] ASYNC_I,
  output logic      [WIDTH-1:0] SYNC_O
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  if (WIDTH < 1)
  begin : g_width_check
    $error("sync_level needs WIDTH of at least one");
  end

  // The first stage feeds only the second stage.
  always_comb
  begin
    meta_next = meta_reg;
    sync_next = sync_reg;
    if (CE_I)
    begin
      meta_next = ASYNC_I;
      sync_next = meta_reg;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign SYNC_O = sync_reg;

endmodule

// *** logic/timer2_control_reload.sv ***
`timescale 1ns/1ps
module timer2_control_reload (
  input  wire logic       MCLK_I,
  input  wire logic       RST_I,
  input  wire logic       CE_I,
  input  wire logic [7:0] SFR_ADDR_I,
  input  wire logic [7:0] SFR_WDATA_I,
  input  wire logic       SFR_WE_I,
  output logic      [7:0] SFR_RDATA_O,
  input  wire logic       HIGH_BYTE_CLOCK_SELECT_I,
  input  wire logic       LOW_BYTE_CLOCK_SELECT_I,
  input  wire logic       TIMER_IRQ_ENABLE_I,
  input  wire logic       CMP0_I,
  input  wire logic       RTC_CLK_I,
  output logic            TIMER_IRQ_O
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] control_reg;
  logic [7:0] control_next;
  logic [7:0] reload_lo_reg;
  logic [7:0] reload_lo_next;
  logic [7:0] reload_hi_reg;
  logic [7:0] reload_hi_next;
  logic [7:0] count_lo_reg;
  logic [7:0] count_lo_next;
  logic [7:0] count_hi_reg;
  logic [7:0] count_hi_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] core_div_reg;
  logic [3:0] core_div_next;
  logic [2:0] rtc_div_reg;
  logic [2:0] rtc_div_next;
  logic [1:0] prev_reg;
  logic [1:0] prev_next;
  logic [1:0] sync_src;
  logic       cmp0_edge;
  logic       rtc_edge;
  logic       core12_tick;
  logic       rtc8_tick;
  logic       ext_tick;
  logic       cap_tick;
  logic       lo_tick;
  logic       hi_tick;
  logic       run;
  logic       split;
  logic       lo_wrap;
  logic       hi_wrap;

  // ----------------------------------------------------------------
  // Source synchronisation and prescalers
  // ----------------------------------------------------------------
  sync_level #(
    .WIDTH (timer2_pkg::SYNC_STAGES)
  ) u_sync (
    .MCLK_I  (MCLK_I),
    .RST_I   (RST_I),
    .CE_I    (CE_I),
    .ASYNC_I ({RTC_CLK_I, CMP0_I}),
    .SYNC_O  (sync_src)
  );

  assign cmp0_edge   = sync_src[0] & ~prev_reg[0];
  assign rtc_edge    = sync_src[1] & ~prev_reg[1];
  assign core12_tick = (core_div_reg == timer2_pkg::CORE_DIV_LAST);
  assign rtc8_tick   = rtc_edge & (rtc_div_reg == timer2_pkg::RTC_DIV_LAST);

  always_comb
  begin
    prev_next     = prev_reg;
    core_div_next = core_div_reg;
    rtc_div_next  = rtc_div_reg;
    if (CE_I)
    begin
      prev_next     = sync_src;
      core_div_next = core12_tick ? 4'h0 : core_div_reg + 4'h1;
      if (rtc_edge)
        rtc_div_next = rtc_div_reg + 3'h1;
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      prev_reg     <= 2'h0;
      core_div_reg <= 4'h0;
      rtc_div_reg  <= 3'h0;
    end
    else
    begin
      prev_reg     <= prev_next;
      core_div_reg <= core_div_next;
      rtc_div_reg  <= rtc_div_next;
    end
  end

  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  always_comb
  begin
    case (control_reg[timer2_pkg::BIT_XCLK_HI:timer2_pkg::BIT_XCLK_LO])
      timer2_pkg::XCLK_DIV12_A: ext_tick = core12_tick;
      timer2_pkg::XCLK_CMP0:    ext_tick = cmp0_edge;
      timer2_pkg::XCLK_DIV12_B: ext_tick = core12_tick;
      timer2_pkg::XCLK_RTC8:    ext_tick = rtc8_tick;
      default:                  ext_tick = 1'b0;
    endcase
  end

  // Capture trigger follows the upper bit of the select field.
  assign cap_tick = control_reg[timer2_pkg::BIT_XCLK_HI] ? cmp0_edge : rtc8_tick;
  assign lo_tick  = LOW_BYTE_CLOCK_SELECT_I | ext_tick;
  assign hi_tick  = HIGH_BYTE_CLOCK_SELECT_I | ext_tick;
  assign run      = control_reg[timer2_pkg::BIT_RUN];
  assign split    = control_reg[timer2_pkg::BIT_SPLIT];
  assign lo_wrap  = count_lo_reg == timer2_pkg::BYTE_MAX;
  assign hi_wrap  = count_hi_reg == timer2_pkg::BYTE_MAX;

  // ----------------------------------------------------------------
  // Counter, flags and register file
  // ----------------------------------------------------------------
  // Software writes to the count bytes override counting in the same cycle,
  // while hardware flag sets win over a software clear so no overflow is lost.
  always_comb
  begin
    control_next   = control_reg;
    reload_lo_next = reload_lo_reg;
    reload_hi_next = reload_hi_reg;
    count_lo_next  = count_lo_reg;
    count_hi_next  = count_hi_reg;
    rdata_next     = rdata_reg;
    if (CE_I)
    begin
      if (SFR_WE_I && SFR_ADDR_I == timer2_pkg::ADDR_CONTROL)
        control_next = SFR_WDATA_I;
      if (split)
      begin
        if (lo_tick)
        begin
          count_lo_next = lo_wrap ? reload_lo_reg : count_lo_reg + 8'h01;
          if (lo_wrap)
            control_next[timer2_pkg::BIT_LOW_FLAG] = 1'b1;
        end
        if (run && hi_tick)
        begin
          count_hi_next = hi_wrap ? reload_hi_reg : count_hi_reg + 8'h01;
          if (hi_wrap)
            control_next[timer2_pkg::BIT_HIGH_FLAG] = 1'b1;
        end
      end
      else if (run && lo_tick)
      begin
        if (lo_wrap)
        begin
          control_next[timer2_pkg::BIT_LOW_FLAG] = 1'b1;
          if (hi_wrap)
          begin
            count_lo_next = reload_lo_reg;
            count_hi_next = reload_hi_reg;
            control_next[timer2_pkg::BIT_HIGH_FLAG] = 1'b1;
          end
          else
          begin
            count_lo_next = 8'h00;
            count_hi_next = count_hi_reg + 8'h01;
          end
        end
        else
          count_lo_next = count_lo_reg + 8'h01;
      end
      // A capture copies the running count into the reload pair.
      if (control_reg[timer2_pkg::BIT_CAPTURE_EN] && cap_tick)
      begin
        reload_lo_next = count_lo_reg;
        reload_hi_next = count_hi_reg;
        control_next[timer2_pkg::BIT_HIGH_FLAG] = 1'b1;
      end
      if (SFR_WE_I)
      begin
        case (SFR_ADDR_I)
          timer2_pkg::ADDR_RELOAD_LOW:  reload_lo_next = SFR_WDATA_I;
          timer2_pkg::ADDR_RELOAD_HIGH: reload_hi_next = SFR_WDATA_I;
          timer2_pkg::ADDR_COUNT_LOW:   count_lo_next  = SFR_WDATA_I;
          timer2_pkg::ADDR_COUNT_HIGH:  count_hi_next  = SFR_WDATA_I;
          default:                      rdata_next     = rdata_reg;
        endcase
      end
      case (SFR_ADDR_I)
        timer2_pkg::ADDR_CONTROL:     rdata_next = control_reg;
        timer2_pkg::ADDR_RELOAD_LOW:  rdata_next = reload_lo_reg;
        timer2_pkg::ADDR_RELOAD_HIGH: rdata_next = reload_hi_reg;
        timer2_pkg::ADDR_COUNT_LOW:   rdata_next = count_lo_reg;
        timer2_pkg::ADDR_COUNT_HIGH:  rdata_next = count_hi_reg;
        default:                      rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge MCLK_I)
  begin
    if (RST_I)
    begin
      control_reg   <= timer2_pkg::RESET_BYTE;
      reload_lo_reg <= timer2_pkg::RESET_BYTE;
      reload_hi_reg <= timer2_pkg::RESET_BYTE;
      count_lo_reg  <= timer2_pkg::RESET_BYTE;
      count_hi_reg  <= timer2_pkg::RESET_BYTE;
      rdata_reg     <= timer2_pkg::RESET_BYTE;
    end
    else
    begin
      control_reg   <= control_next;
      reload_lo_reg <= reload_lo_next;
      reload_hi_reg <= reload_hi_next;
      count_lo_reg  <= count_lo_next;
      count_hi_reg  <= count_hi_next;
      rdata_reg     <= rdata_next;
    end
  end

  assign SFR_RDATA_O = rdata_reg;
  assign TIMER_IRQ_O = TIMER_IRQ_ENABLE_I & (control_reg[timer2_pkg::BIT_HIGH_FLAG] |
                       (control_reg[timer2_pkg::BIT_LOW_FLAG] & control_reg[timer2_pkg::BIT_LOW_IRQ_EN]));

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (RST_I);

  logic no_write;
  logic quiet;
  assign no_write = ~SFR_WE_I;
  assign quiet    = CE_I & no_write & ~control_reg[timer2_pkg::BIT_CAPTURE_EN];

  sequence write_to(logic [7:0] addr);
    CE_I && SFR_WE_I && SFR_ADDR_I == addr;
  endsequence

  sequence full_wrap;
    quiet && !split && run && lo_tick && lo_wrap && hi_wrap;
  endsequence

  hold_stopped_a: assert property (quiet && !split && !run |=> $stable({count_hi_reg, count_lo_reg}))
    else $error("counter moved while stopped");
  split_low_free_a: assert property (quiet && split && !run && LOW_BYTE_CLOCK_SELECT_I && !lo_wrap
    |=> count_lo_reg == $past(count_lo_reg) + 8'h01 && $stable(count_hi_reg))
    else $error("split low byte did not count");
  reload_full_a: assert property (full_wrap |=> {count_hi_reg, count_lo_reg} == $past({reload_hi_reg, reload_lo_reg}))
    else $error("16-bit reload missing");
  high_flag_set_a: assert property (full_wrap |=> control_reg[7] && control_reg[6])
    else $error("high overflow flag not set");
  low_flag_set_a: assert property (quiet && split && lo_tick && lo_wrap |=> control_reg[6] &&
    count_lo_reg == $past(reload_lo_reg))
    else $error("low overflow flag not set");
  flag_sticky_a: assert property (control_reg[7] && !(SFR_WE_I && SFR_ADDR_I == timer2_pkg::ADDR_CONTROL)
    |=> control_reg[7])
    else $error("high flag cleared by hardware");
  mode16_carry_a: assert property (quiet && !split && run && lo_tick && lo_wrap && !hi_wrap
    |=> count_lo_reg == 8'h00 && count_hi_reg == $past(count_hi_reg) + 8'h01)
    else $error("16-bit carry wrong");
  reload_low_rw_a: assert property (write_to(timer2_pkg::ADDR_RELOAD_LOW) ##1 (CE_I && no_write &&
    SFR_ADDR_I == timer2_pkg::ADDR_RELOAD_LOW && !control_reg[4]) |=> SFR_RDATA_O == $past(SFR_WDATA_I, 2))
    else $error("reload low readback wrong");
  reload_high_rw_a: assert property (write_to(timer2_pkg::ADDR_RELOAD_HIGH) |=> reload_hi_reg == $past(SFR_WDATA_I))
    else $error("reload high write lost");
  count_low_rw_a: assert property (write_to(timer2_pkg::ADDR_COUNT_LOW) |=> count_lo_reg == $past(SFR_WDATA_I))
    else $error("count low write lost");
  count_high_rw_a: assert property (write_to(timer2_pkg::ADDR_COUNT_HIGH) |=> count_hi_reg == $past(SFR_WDATA_I))
    else $error("count high write lost");
  irq_low_a: assert property (control_reg[6] && control_reg[5] && TIMER_IRQ_ENABLE_I |-> TIMER_IRQ_O)
    else $error("low overflow irq missing");

endmodule

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic       mclk_i = 1'b0;
  logic       rst_i  = 1'b1;
  logic       ce_i   = 1'b1;
  logic [7:0] addr   = 8'h00;
  logic [7:0] wdata  = 8'h00;
  logic       we     = 1'b0;
  logic [7:0] rdata;
  logic       hsel   = 1'b1;
  logic       lsel   = 1'b1;
  logic       irq_en = 1'b0;
  logic       cmp0   = 1'b0;
  logic       rtc    = 1'b0;
  logic       irq;
  int         num_errors = 0;
  int         compares = 0;

  timer2_control_reload timer2_control_reload_i (
    .MCLK_I                   (mclk_i),
    .RST_I                    (rst_i),
    .CE_I                     (ce_i),
    .SFR_ADDR_I               (addr),
    .SFR_WDATA_I              (wdata),
    .SFR_WE_I                 (we),
    .SFR_RDATA_O              (rdata),
    .HIGH_BYTE_CLOCK_SELECT_I (hsel),
    .LOW_BYTE_CLOCK_SELECT_I  (lsel),
    .TIMER_IRQ_ENABLE_I       (irq_en),
    .CMP0_I                   (cmp0),
    .RTC_CLK_I                (rtc),
    .TIMER_IRQ_O              (irq)
  );

  initial
  begin
    forever #2.5 mclk_i = ~mclk_i;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic idle(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr  <= a;
    wdata <= d;
    we    <= 1'b1;
    @(posedge mclk_i);
    we    <= 1'b0;
  endtask

  // Read data is registered, so it is sampled one edge after the address.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    @(posedge mclk_i);
    #1;
    d = rdata;
  endtask

  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    compares++;
    if (d !== e)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: reg %h read %h expected %h", $time, a, d, e);
    end
  endtask

  // A running counter can only be bounded, not pinned to one value.
  task automatic chk_rng(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] d;
    rd(a, d);
    compares++;
    if ((d >= lo && d <= hi) !== 1'b1)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: reg %h read %h outside %h..%h", $time, a, d, lo, hi);
    end
  endtask

  task automatic chk_irq(input logic e);
    @(posedge mclk_i);
    #1;
    compares++;
    if (irq !== e)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: interrupt request %b expected %b", $time, irq, e);
    end
  endtask

  task automatic cmp_pulse();
    cmp0 <= 1'b1;
    idle(3);
    cmp0 <= 1'b0;
    idle(3);
  endtask

  task automatic rtc_edges(input int n);
    repeat (n)
    begin
      rtc <= 1'b1;
      idle(2);
      rtc <= 1'b0;
      idle(2);
    end
  endtask

  task automatic complete_run();
    if (num_errors == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    #50000;
    num_errors++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    complete_run();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    idle(5);
    rst_i <= 1'b0;
    chk(8'hCA, 8'h00);
    chk(8'hCB, 8'h00);
    chk(8'hCC, 8'h00);
    chk(8'hCD, 8'h00);
    chk(8'hC8, 8'h00);
    chk(8'hC9, 8'h00);
    wr(8'hCA, 8'h55);
    wr(8'hCB, 8'hAA);
    chk(8'hCA, 8'h55);
    chk(8'hCB, 8'hAA);
    @(posedge mclk_i);
    ce_i <= 1'b0;
    wr(8'hCA, 8'h11);
    ce_i <= 1'b1;
    chk(8'hCA, 8'h55);
    // Held counter, then a full 16-bit wrap with reload.
    wr(8'hCC, 8'h77);
    idle(20);
    chk(8'hCC, 8'h77);
    wr(8'hCA, 8'h34);
    wr(8'hCB, 8'h12);
    wr(8'hCD, 8'hFF);
    wr(8'hCC, 8'hF0);
    wr(8'hC8, 8'h04);
    idle(40);
    chk(8'hC8, 8'hC4);
    wr(8'hC8, 8'hC0);
    chk(8'hCD, 8'h12);
    chk_rng(8'hCC, 8'h40, 8'h60);
    chk(8'hC8, 8'hC0);
    @(posedge mclk_i);
    irq_en <= 1'b1;
    chk_irq(1'b1);
    wr(8'hC8, 8'h40);
    chk_irq(1'b0);
    wr(8'hC8, 8'h60);
    chk_irq(1'b1);
    @(posedge mclk_i);
    irq_en <= 1'b0;
    chk_irq(1'b0);
    wr(8'hC8, 8'h00);
    chk(8'hC8, 8'h00);
    // Low byte wrap alone carries into the high byte in 16-bit mode.
    wr(8'hCD, 8'h10);
    wr(8'hCC, 8'hF0);
    wr(8'hC8, 8'h04);
    idle(30);
    chk(8'hC8, 8'h44);
    wr(8'hC8, 8'h40);
    chk(8'hCD, 8'h11);
    chk(8'hC8, 8'h40);
    // Split mode: low byte runs without run control, high byte needs it.
    wr(8'hCA, 8'h80);
    wr(8'hCB, 8'h40);
    wr(8'hCD, 8'h10);
    wr(8'hCC, 8'hF0);
    wr(8'hC8, 8'h08);
    idle(40);
    chk_rng(8'hCC, 8'h80, 8'hB0);
    chk(8'hCD, 8'h10);
    chk(8'hC8, 8'h48);
    wr(8'hCD, 8'hF0);
    wr(8'hC8, 8'h0C);
    idle(30);
    chk(8'hC8, 8'h8C);
    wr(8'hC8, 8'h08);
    chk_rng(8'hCD, 8'h40, 8'h58);
    // Per-byte select: low byte on an idle comparator, high byte on core clock.
    @(posedge mclk_i);
    lsel <= 1'b0;
    wr(8'hC8, 8'h0D);
    wr(8'hCD, 8'h00);
    wr(8'hCC, 8'h22);
    idle(20);
    chk(8'hCC, 8'h22);
    chk_rng(8'hCD, 8'h10, 8'h24);
    // Swapped selects: low byte on the core clock, high byte on the idle comparator.
    @(posedge mclk_i);
    lsel <= 1'b1;
    hsel <= 1'b0;
    wr(8'hCD, 8'h33);
    idle(20);
    chk(8'hCD, 8'h33);
    chk_rng(8'hCC, 8'h30, 8'h44);
    @(posedge mclk_i);
    lsel <= 1'b0;
    // External sources in 16-bit mode.
    wr(8'hC8, 8'h05);
    wr(8'hCD, 8'h00);
    wr(8'hCC, 8'h00);
    repeat (5) cmp_pulse();
    idle(4);
    chk(8'hCC, 8'h05);
    wr(8'hC8, 8'h07);
    wr(8'hCC, 8'h00);
    rtc_edges(16);
    idle(4);
    chk(8'hCC, 8'h02);
    for (int i = 0; i < 2; i++)
    begin
      wr(8'hC8, i == 0 ? 8'h04 : 8'h06);
      wr(8'hCC, 8'h00);
      idle(120);
      chk_rng(8'hCC, 8'h09, 8'h0B);
    end
    // Capture triggers copy the held count into the reload registers.
    @(posedge mclk_i);
    lsel <= 1'b1;
    wr(8'hC8, 8'h10);
    wr(8'hCD, 8'h34);
    wr(8'hCC, 8'h56);
    rtc_edges(8);
    idle(4);
    chk(8'hCB, 8'h34);
    chk(8'hCA, 8'h56);
    chk(8'hC8, 8'h90);
    wr(8'hC8, 8'h12);
    wr(8'hCD, 8'h78);
    wr(8'hCC, 8'h9A);
    cmp_pulse();
    idle(4);
    chk(8'hCB, 8'h78);
    chk(8'hCA, 8'h9A);
    chk(8'hC8, 8'h92);
    // A second reset in mid-run must bring the registers back to zero.
    @(posedge mclk_i);
    rst_i <= 1'b1;
    idle(2);
    rst_i <= 1'b0;
    chk(8'hC8, 8'h00);
    chk(8'hCA, 8'h00);
    complete_run();
  end
endmodule
